// ===== core/ptgp_top.sv
// Purpose: trigger, sequencer loop-back, general and FPGA config pins
// Assumes: all pin inputs asynchronous, one 250 MHz clock
// Notes:   outputs all registered; secondary role keeps pins quiet
//
// Notes on behaviour
// - video pattern mode: advance input edge steps to the next pattern
// - video pattern mode: rising edge of run input starts the sequence
// - video pattern mode: falling edge of run input halts the sequence
// - software start and stop commands govern the run as well
// - exposure output high for each pattern exposure, low otherwise
// - first-pattern output high while the first pattern is shown
// - each pin: input, output, bidirectional or open-drain; pins zero to three also alternate use
// - after reset every general pin is an input
// - pins zero to three may carry the PWM output of same index
// - pins four to eight offer only general pin use
// - loop output a is a sequencing interrupt, looped to input a
// - loop output b is a sequencing interrupt, looped to input b
// - split config pin driven high by default
// - secondary role: trigger, general and config pins inactive
// - loop inputs taken as asynchronous sequencing interrupt sources
// - role pin high means primary, low means secondary
//
// Register access over Wishbone and the address map were chosen for this implementation.
`default_nettype none

module ptgp_top
	import ptgp_pkg::*;
#(
	parameter int GPIO_N = 9,
	parameter int PWM_N  = 4
) (
	// clock and reset
	input  wire logic                sys_clk_i,
	input  wire logic                rst_i,
	// register bus
	input  wire logic [ADDR_W-1:0]   wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic                wb_we_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_cyc_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	// triggers
	input  wire logic                pattern_advance_in_i,
	input  wire logic                pattern_run_in_i,
	output logic                     exposure_active_out_o,
	output logic                     first_pattern_out_o,
	// sequencer loop-back
	output logic                     seq_loop_out_a_o,
	output logic                     seq_loop_out_b_o,
	input  wire logic                seq_loop_in_a_i,
	input  wire logic                seq_loop_in_b_i,
	// role and PWM sources
	input  wire logic                ctrl_role_i,
	input  wire logic [PWM_N-1:0]    pwm_i,
	// general pins
	input  wire logic [GPIO_N-1:0]   gpio_i,
	output logic [GPIO_N-1:0]        gpio_o,
	output logic [GPIO_N-1:0]        gpio_oe_o,
	// FPGA config pins
	input  wire ptgp_cfg_type        fpga_cfg_i,
	output ptgp_cfg_type             fpga_cfg_o,
	output ptgp_cfg_type             fpga_cfg_oe_o
);

	localparam int SW = 5 + GPIO_N + 5;

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	logic [SW-1:0]     sync1;
	logic [SW-1:0]     sync2;
	logic [SW-1:0]     sync3;
	logic              adv_s, run_s, la_s, lb_s, role_s;
	logic              adv_rise, run_rise, run_fall, la_rise, lb_rise;
	logic [GPIO_N-1:0] gpio_s;
	logic [4:0]        cfg_s;

	// sync1 feeds sync2 only; edges use sync2 against sync3
	always_ff @(posedge sys_clk_i) begin
		sync1 <= {pattern_advance_in_i, pattern_run_in_i, seq_loop_in_a_i,
			seq_loop_in_b_i, ctrl_role_i, gpio_i, fpga_cfg_i};
		sync2 <= sync1;
		sync3 <= sync2;
	end

	assign {adv_s, run_s, la_s, lb_s, role_s, gpio_s, cfg_s} = sync2;
	assign adv_rise = adv_s & ~sync3[SW-1];
	assign run_rise = run_s & ~sync3[SW-2];
	assign run_fall = ~run_s & sync3[SW-2];
	assign la_rise  = la_s & ~sync3[SW-3];
	assign lb_rise  = lb_s & ~sync3[SW-4];

	// ------------------------------------------------------------
	// role capture
	// ------------------------------------------------------------
	logic [1:0] role_cnt;
	logic       role_valid;
	logic       primary;
	logic       act;

	// sampled once the synchroniser holds real pin values
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			role_cnt   <= 2'h0;
			role_valid <= 1'b0;
			primary    <= 1'b0;
		end else if (!role_valid) begin
			if (role_cnt == ROLE_WAIT) begin
				role_valid <= 1'b1;
				primary    <= role_s;
			end else begin
				role_cnt <= role_cnt + 2'h1;
			end
		end
	end

	assign act = role_valid & primary;

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	logic [31:0]         wmask, wdat;
	logic                wr;
	logic                ctrl_mode;
	logic [7:0]          seq_len;
	logic [15:0]         seq_expo;
	logic [2*GPIO_N-1:0] gmode;
	logic [GPIO_N-1:0]   gout, gen;
	logic [PWM_N-1:0]    galt;
	logic [4:0]          cfg_val, cfg_oe;
	logic [1:0]          loop_flag;
	logic                sw_start, sw_stop;
	logic [31:0]         next_rdata;

	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat  = wb_dat_i & wmask;
	// write lands on the edge where the master samples ack
	assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign sw_start = wr && wb_adr_i == CTRL_OFS && wdat[CTRL_START];
	assign sw_stop  = wr && wb_adr_i == CTRL_OFS && wdat[CTRL_STOP];

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl_mode <= 1'b0;
			seq_len   <= SEQ_LEN_RST;
			seq_expo  <= SEQ_EXPO_RST;
			gmode     <= '0;
			gout      <= '0;
			gen       <= '0;
			galt      <= '0;
			cfg_val   <= FCFG_VAL_RST;
			cfg_oe    <= FCFG_OE_RST;
		end else if (wr) begin
			unique case (wb_adr_i)
				CTRL_OFS: if (wb_sel_i[0]) ctrl_mode <= wb_dat_i[CTRL_MODE];
				SEQ_OFS: begin
					if (wb_sel_i[0]) seq_len <= wb_dat_i[SEQ_LEN_LSB +: 8];
					if (wb_sel_i[2]) seq_expo[7:0] <= wb_dat_i[SEQ_EXPO_LSB +: 8];
					if (wb_sel_i[3]) seq_expo[15:8] <= wb_dat_i[SEQ_EXPO_LSB+8 +: 8];
				end
				GMODE_OFS: gmode <= (gmode & ~wmask[2*GPIO_N-1:0]) | wdat[2*GPIO_N-1:0];
				GOUT_OFS: begin
					gout <= (gout & ~wmask[GPIO_N-1:0]) | wdat[GPIO_N-1:0];
					gen  <= (gen & ~wmask[GOUT_EN_LSB +: GPIO_N])
						| wdat[GOUT_EN_LSB +: GPIO_N];
				end
				GALT_OFS: galt <= (galt & ~wmask[PWM_N-1:0]) | wdat[PWM_N-1:0];
				FCFG_OFS: begin
					if (wb_sel_i[0]) cfg_val <= wb_dat_i[4:0];
					if (wb_sel_i[1]) cfg_oe <= wb_dat_i[FCFG_OE_LSB +: 5];
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	ptgp_state_type state, next_state;
	logic [7:0]     idx, next_idx, len_m1;
	logic [15:0]    expo_cnt;
	logic           step, start_go, stop_go;

	assign len_m1   = (seq_len == 8'h00) ? 8'h00 : seq_len - 8'h01;
	assign stop_go  = sw_stop | (ctrl_mode & run_fall) | ~act;
	assign start_go = act & (sw_start | (ctrl_mode & run_rise));

	always_comb begin
		next_state = state;
		next_idx   = idx;
		step       = 1'b0;
		unique case (state)
			PTGP_IDLE: begin
				if (start_go && !stop_go) begin
					next_state = PTGP_RUN;
					next_idx   = 8'h00;
					step       = 1'b1;
				end
			end
			PTGP_RUN: begin
				if (stop_go) begin
					next_state = PTGP_IDLE;
				end else if (ctrl_mode && adv_rise) begin
					next_idx = (idx >= len_m1) ? 8'h00 : idx + 8'h01;
					step     = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= PTGP_IDLE;
			idx   <= 8'h00;
		end else begin
			state <= next_state;
			idx   <= next_idx;
		end
	end

	// exposure lasts seq_expo cycles; zero is taken as one
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			exposure_active_out_o <= 1'b0;
			expo_cnt              <= 16'h0000;
		end else if (next_state != PTGP_RUN) begin
			exposure_active_out_o <= 1'b0;
			expo_cnt              <= 16'h0000;
		end else if (step) begin
			exposure_active_out_o <= 1'b1;
			expo_cnt <= (seq_expo == 16'h0000) ? 16'h0000 : seq_expo - 16'h0001;
		end else if (expo_cnt != 16'h0000) begin
			expo_cnt <= expo_cnt - 16'h0001;
		end else begin
			exposure_active_out_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			first_pattern_out_o <= 1'b0;
			seq_loop_out_a_o    <= 1'b0;
			seq_loop_out_b_o    <= 1'b0;
		end else begin
			first_pattern_out_o <= next_state == PTGP_RUN && next_idx == 8'h00;
			seq_loop_out_a_o    <= step;
			seq_loop_out_b_o    <= step && next_idx == 8'h00;
		end
	end

	// loop-back flags: set wins over a write-one clear
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			loop_flag <= 2'b00;
		end else begin
			loop_flag <= (loop_flag & ~((wr && wb_adr_i == STAT_OFS)
				? wdat[STAT_LOOPB:STAT_LOOPA] : 2'b00)) | {lb_rise, la_rise};
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			CTRL_OFS: next_rdata[CTRL_MODE] = ctrl_mode;
			SEQ_OFS:  next_rdata = {seq_expo, 8'h00, seq_len};
			STAT_OFS: begin
				next_rdata[STAT_RUN]             = state == PTGP_RUN;
				next_rdata[STAT_PRIM]            = primary;
				next_rdata[STAT_ROLE]            = role_valid;
				next_rdata[STAT_LOOPB:STAT_LOOPA] = loop_flag;
				next_rdata[STAT_IDX +: 8]        = idx;
				next_rdata[STAT_ADV]             = adv_s;
				next_rdata[STAT_RUNIN]           = run_s;
			end
			GMODE_OFS: next_rdata[2*GPIO_N-1:0] = gmode;
			GOUT_OFS: begin
				next_rdata[GPIO_N-1:0]             = gout;
				next_rdata[GOUT_EN_LSB +: GPIO_N] = gen;
			end
			GALT_OFS: next_rdata[PWM_N-1:0] = galt;
			GIN_OFS:  next_rdata[GPIO_N-1:0] = gpio_s;
			FCFG_OFS: begin
				next_rdata[4:0]               = cfg_val;
				next_rdata[FCFG_OE_LSB +: 5] = cfg_oe;
				next_rdata[FCFG_IN_LSB +: 5] = cfg_s;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	logic [GPIO_N-1:0] next_go, next_goe, od_eff;

	for (genvar i = 0; i < GPIO_N; i++) begin : g_pin
		logic [1:0] m;
		logic       alt;
		assign m = gmode[2*i +: 2];
		if (i < PWM_N) begin : g_pwm
			assign alt = galt[i];
		end else begin : g_gp
			assign alt = 1'b0;
		end
		assign od_eff[i]   = !alt && m == GM_OD;
		assign next_go[i]  = alt ? pwm_i[i % PWM_N] : (m != GM_OD) & gout[i];
		assign next_goe[i] = act & (alt | (m == GM_OUT) | (m == GM_BIDIR && gen[i])
			| (m == GM_OD && !gout[i]));
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			gpio_o        <= '0;
			gpio_oe_o     <= '0;
			fpga_cfg_o    <= '0;
			fpga_cfg_oe_o <= '0;
		end else begin
			gpio_o        <= act ? next_go : '0;
			gpio_oe_o     <= next_goe;
			fpga_cfg_o    <= act ? cfg_val : 5'h00;
			fpga_cfg_oe_o <= act ? cfg_oe : 5'h00;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	logic [GPIO_N-1:0] od_q;
	always_ff @(posedge sys_clk_i) od_q <= od_eff;

	sequence s_run_start;
		state == PTGP_IDLE && act && ctrl_mode && run_rise && !sw_stop;
	endsequence
	sequence s_adv;
		state == PTGP_RUN && act && ctrl_mode && adv_rise && !run_fall && !sw_stop;
	endsequence

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_run_start: assert property (s_run_start |=> state == PTGP_RUN
		##0 first_pattern_out_o ##0 seq_loop_out_b_o)
		else $error("run edge did not start sequence");
	// exposure drops on the same edge as the state, so a quick restart is no false hit
	a_run_stop: assert property (state == PTGP_RUN && ctrl_mode && run_fall
		|=> state == PTGP_IDLE && !exposure_active_out_o)
		else $error("run fall did not halt sequence");
	a_adv_step: assert property (s_adv |=>
		idx == (($past(idx) >= $past(len_m1)) ? 8'h00 : $past(idx) + 8'h01)
		##0 seq_loop_out_a_o)
		else $error("advance edge did not step pattern");
	a_expo_on: assert property (s_adv ##1 (seq_expo > 16'h0002) |=>
		exposure_active_out_o [*2])
		else $error("exposure not held after step");
	// a wrap back to index zero must raise the output too
	a_first_pat: assert property ($past(state) == PTGP_RUN && state == PTGP_RUN
		|-> first_pattern_out_o == (idx == 8'h00))
		else $error("first pattern output wrong");
	a_od_low: assert property (~|(gpio_o & gpio_oe_o & od_q))
		else $error("open-drain pin drove high");
	a_second_quiet: assert property (!act |=> gpio_oe_o == '0
		&& fpga_cfg_oe_o == 5'h00 && !exposure_active_out_o)
		else $error("secondary role drives pins");
	a_loop_sticky: assert property (la_rise |=> loop_flag[0])
		else $error("loop input edge lost");
	a_split_high: assert property (act && cfg_val[2] && cfg_oe[2]
		|=> fpga_cfg_o.split && fpga_cfg_oe_o.split)
		else $error("split config pin not driven high");

endmodule : ptgp_top

`default_nettype wire

// ===== core/ptgp_pkg.sv
// Purpose: shared constants and types of the trigger and pin block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   reset values of the sequencer fields are plain defaults
`default_nettype none

package ptgp_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          ADDR_W    = 6;
	localparam logic [5:0]  CTRL_OFS  = 6'h00;
	localparam logic [5:0]  SEQ_OFS   = 6'h04;
	localparam logic [5:0]  STAT_OFS  = 6'h08;
	localparam logic [5:0]  GMODE_OFS = 6'h0C;
	localparam logic [5:0]  GOUT_OFS  = 6'h10;
	localparam logic [5:0]  GALT_OFS  = 6'h14;
	localparam logic [5:0]  GIN_OFS   = 6'h18;
	localparam logic [5:0]  FCFG_OFS  = 6'h1C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_MODE  = 0;
	localparam int CTRL_START = 1;
	localparam int CTRL_STOP  = 2;
	localparam int SEQ_LEN_LSB  = 0;
	localparam int SEQ_EXPO_LSB = 16;
	localparam int STAT_RUN   = 0;
	localparam int STAT_PRIM  = 1;
	localparam int STAT_ROLE  = 2;
	localparam int STAT_LOOPA = 3;
	localparam int STAT_LOOPB = 4;
	localparam int STAT_IDX   = 8;
	localparam int STAT_ADV   = 16;
	localparam int STAT_RUNIN = 17;
	localparam int GOUT_EN_LSB  = 16;
	localparam int FCFG_OE_LSB  = 8;
	localparam int FCFG_IN_LSB  = 16;

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0]  SEQ_LEN_RST  = 8'h08;
	localparam logic [15:0] SEQ_EXPO_RST = 16'h0100;
	localparam logic [4:0]  FCFG_VAL_RST = 5'h04;
	localparam logic [4:0]  FCFG_OE_RST  = 5'h04;
	localparam logic [1:0]  ROLE_WAIT    = 2'h3;

	// ------------------------------------------------------------
	// general-purpose pin modes
	// ------------------------------------------------------------
	localparam logic [1:0] GM_IN    = 2'h0;
	localparam logic [1:0] GM_OUT   = 2'h1;
	localparam logic [1:0] GM_BIDIR = 2'h2;
	localparam logic [1:0] GM_OD    = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic e;
		logic d;
		logic split;
		logic b;
		logic a;
	} ptgp_cfg_type;

	typedef enum logic [1:0] {
		PTGP_IDLE = 2'b01,
		PTGP_RUN  = 2'b10
	} ptgp_state_type;

endpackage : ptgp_pkg

`default_nettype wire

// ===== testbench/ptgp_far_model.sv
// Purpose: far side of the trigger and pin block: camera, sensor, board
// Assumes: board pull-ups on general pins, loop outputs wired to loop inputs
// Notes:   advance pulse is 4 cycles high then 4 low
`default_nettype none

module ptgp_far_model
	import ptgp_pkg::*;
(
	// clock and bench commands
	input  wire logic         sys_clk_i,
	input  wire logic         run_req_i,
	input  wire logic         adv_req_i,
	input  wire logic         ext_en_i,
	input  wire logic [8:0]   ext_val_i,
	// design side
	input  wire logic         loop_a_i,
	input  wire logic         loop_b_i,
	input  wire logic [8:0]   gpio_d_i,
	input  wire logic [8:0]   gpio_oe_i,
	input  wire ptgp_cfg_type cfg_d_i,
	input  wire ptgp_cfg_type cfg_oe_i,
	// pin levels back to the design
	output logic              run_o,
	output logic              adv_o,
	output logic              loop_a_o,
	output logic              loop_b_o,
	output logic [8:0]        gpio_o,
	output ptgp_cfg_type      cfg_o
);
	logic [3:0] adv_cnt = 4'h0;
	logic       flip    = 1'b0;

	initial run_o = 1'b0;
	always @(posedge sys_clk_i) begin
		run_o <= run_req_i;
		flip  <= ~flip;
		if (adv_req_i)
			adv_cnt <= 4'h8;
		else if (adv_cnt != 4'h0)
			adv_cnt <= adv_cnt - 4'h1;
	end
	assign adv_o    = (adv_cnt > 4'h4);
	assign loop_a_o = loop_a_i;
	assign loop_b_o = loop_b_i;
	// released pins sit at the pull-up unless the far side drives them
	assign gpio_o = (gpio_oe_i & gpio_d_i) | (~gpio_oe_i & (ext_en_i ? ext_val_i : 9'h1FF));
	// undriven config pins toggle so a stale level never reads back
	assign cfg_o = ptgp_cfg_type'((cfg_oe_i & cfg_d_i) | (~cfg_oe_i & {5{flip}}));
endmodule : ptgp_far_model

`default_nettype wire

// ===== testbench/ptgp_top_tb.sv
// Purpose: self-checking bench of the trigger and pin block
// Assumes: Wishbone classic master tasks, one 250 MHz clock
// Notes:   waits after pin edges cover the two-flop synchroniser
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; \
	if ((got) !== (exp)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end

module ptgp_top_tb;
	import ptgp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic         sys_clk, rst, we, stb, cyc, wb_ack, role;
	logic [5:0]   adr;
	logic [31:0]  wdat, wb_dat;
	logic [3:0]   sel, pwm;
	logic         adv_in, run_in, expo, first, lp_a, lp_b, li_a, li_b;
	logic         run_req, adv_req, ext_en;
	logic [8:0]   gin, gout, goe, ext_val;
	ptgp_cfg_type cin, cout, coe;
	int           bad_count, samples_checked, cycles;

	ptgp_top i_ptgp_top (.sys_clk_i(sys_clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_dat_o(wb_dat),
		.wb_ack_o(wb_ack), .pattern_advance_in_i(adv_in), .pattern_run_in_i(run_in),
		.exposure_active_out_o(expo), .first_pattern_out_o(first), .seq_loop_out_a_o(lp_a),
		.seq_loop_out_b_o(lp_b), .seq_loop_in_a_i(li_a), .seq_loop_in_b_i(li_b),
		.ctrl_role_i(role), .pwm_i(pwm), .gpio_i(gin), .gpio_o(gout), .gpio_oe_o(goe),
		.fpga_cfg_i(cin), .fpga_cfg_o(cout), .fpga_cfg_oe_o(coe));

	ptgp_far_model i_ptgp_far_model (.sys_clk_i(sys_clk), .run_req_i(run_req),
		.adv_req_i(adv_req), .ext_en_i(ext_en), .ext_val_i(ext_val), .loop_a_i(lp_a),
		.loop_b_i(lp_b), .gpio_d_i(gout), .gpio_oe_i(goe), .cfg_d_i(cout), .cfg_oe_i(coe),
		.run_o(run_in), .adv_o(adv_in), .loop_a_o(li_a), .loop_b_o(li_b), .gpio_o(gin),
		.cfg_o(cin));

	// ------------------------------------------------------------
	// bus and pin tasks
	// ------------------------------------------------------------
	task automatic wb_cycle(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		adr  <= a;
		wdat <= d;
		we   <= w;
		sel  <= 4'hF;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		q = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 50) `CHK("bus ack", 1'b1, 1'b0)
	endtask : wb_cycle

	task automatic wb_write(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, a, d, q);
	endtask : wb_write

	task automatic adv_pulse;
		@(posedge sys_clk) adv_req <= 1'b1;
		@(posedge sys_clk) adv_req <= 1'b0;
		repeat (12) @(posedge sys_clk);
	endtask : adv_pulse

	task automatic do_reset(input logic r);
		@(posedge sys_clk);
		role <= r;
		rst  <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask : do_reset

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------
	// clock and timeout
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	initial begin
		logic [31:0] r;
		rst             = 1'b1;
		role            = 1'b1;
		adr             = 6'h00;
		wdat            = 32'h0;
		sel             = 4'h0;
		we              = 1'b0;
		stb             = 1'b0;
		cyc             = 1'b0;
		pwm             = 4'h0;
		run_req         = 1'b0;
		adv_req         = 1'b0;
		ext_en          = 1'b0;
		ext_val         = 9'h000;
		bad_count       = 0;
		samples_checked = 0;
		cycles          = 0;
		do_reset(1'b1);
		`CHK("pins input after reset", 9'h000, goe)
		wb_cycle(1'b0, GMODE_OFS, 32'h0, r);
		`CHK("mode reset", 32'h0, r)
		`CHK("split pin", 2'b11, {cout.split, coe.split})
		wb_cycle(1'b0, FCFG_OFS, 32'h0, r);
		`CHK("config reset", 13'h0404, r[12:0])
		`CHK("split readback", 1'b1, r[FCFG_IN_LSB+2])
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("primary role", 2'b11, r[2:1])
		wb_cycle(1'b0, 6'h3C, 32'h0, r);
		`CHK("unmapped read", 32'h0, r)
		$display("test reset done");
		wb_write(GMODE_OFS, 32'h00015555);
		wb_write(GOUT_OFS, 32'h00000155);
		repeat (2) @(posedge sys_clk);
		`CHK("output enable", 9'h1FF, goe)
		`CHK("output data", 9'h155, gout)
		wb_write(GMODE_OFS, 32'h0003FFFF);
		repeat (2) @(posedge sys_clk);
		`CHK("open-drain enable", 9'h0AA, goe)
		`CHK("open-drain never high", 9'h000, gout & goe)
		wb_write(GMODE_OFS, 32'h0002AAAA);
		wb_write(GOUT_OFS, 32'h01F000F0);
		repeat (2) @(posedge sys_clk);
		`CHK("bidir enable", 9'h1F0, goe)
		`CHK("bidir data", 9'h0F0, gout & goe)
		wb_write(GMODE_OFS, 32'h0);
		ext_en  <= 1'b1;
		ext_val <= 9'h0A5;
		pwm     <= 4'hA;
		repeat (4) @(posedge sys_clk);
		wb_cycle(1'b0, GIN_OFS, 32'h0, r);
		`CHK("input level", 9'h0A5, r[8:0])
		wb_write(GALT_OFS, 32'h000001FF);
		repeat (2) @(posedge sys_clk);
		`CHK("pwm enable", 9'h00F, goe)
		`CHK("pwm data", 4'hA, gout[3:0])
		wb_write(GALT_OFS, 32'h0);
		$display("test pins done");
		// a three-pattern list wraps quickly, exposure of 16 cycles
		wb_write(SEQ_OFS, 32'h00100003);
		wb_write(CTRL_OFS, 32'h0);
		run_req <= 1'b1;
		repeat (8) @(posedge sys_clk);
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("run pin without mode", 1'b0, r[0])
		run_req <= 1'b0;
		wb_write(CTRL_OFS, 32'h1);
		repeat (8) @(posedge sys_clk);
		run_req <= 1'b1;
		repeat (6) @(posedge sys_clk);
		`CHK("first at start", 1'b1, first)
		`CHK("exposure at start", 1'b1, expo)
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("running", 1'b1, r[0])
		`CHK("loop flags", 2'b11, r[4:3])
		`CHK("start index", 8'h00, r[15:8])
		wb_write(STAT_OFS, 32'h00000018);
		adv_pulse();
		`CHK("first after step", 1'b0, first)
		`CHK("exposure restarted", 1'b1, expo)
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("step index", 8'h01, r[15:8])
		`CHK("step loop flags", 2'b01, r[4:3])
		repeat (20) @(posedge sys_clk);
		`CHK("exposure ended", 1'b0, expo)
		adv_pulse();
		adv_pulse();
		`CHK("first after wrap", 1'b1, first)
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("wrap index", 8'h00, r[15:8])
		`CHK("wrap loop b", 1'b1, r[4])
		run_req <= 1'b0;
		repeat (8) @(posedge sys_clk);
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("run pin stop", 1'b0, r[0])
		`CHK("first after stop", 1'b0, first)
		wb_write(CTRL_OFS, 32'h3);
		repeat (2) @(posedge sys_clk);
		`CHK("software start", 1'b1, first)
		wb_write(CTRL_OFS, 32'h5);
		repeat (2) @(posedge sys_clk);
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("software stop", 1'b0, r[0])
		$display("test sequence done");
		do_reset(1'b0);
		wb_write(GMODE_OFS, 32'h00015555);
		wb_write(FCFG_OFS, 32'h00001F1F);
		wb_write(CTRL_OFS, 32'h3);
		repeat (4) @(posedge sys_clk);
		`CHK("secondary pins", 9'h000, goe)
		`CHK("secondary config", 5'h00, coe)
		`CHK("secondary exposure", 1'b0, expo)
		wb_cycle(1'b0, STAT_OFS, 32'h0, r);
		`CHK("secondary role", 2'b10, r[2:1])
		$display("test secondary done");
		give_verdict();
	end
endmodule : ptgp_top_tb

`default_nettype wire
